// File: src/srx_regs.vh
`ifndef SRX_REGS_VH
`define SRX_REGS_VH

// Register byte addresses
`define SRX_ADDR_CTRL      32'h4000_8000
`define SRX_ADDR_MODE      32'h4000_8004
`define SRX_ADDR_RXWORD    32'h4000_8008
`define SRX_ADDR_TXDATA    32'h4000_800C
`define SRX_ADDR_STATUS    32'h4000_8010
`define SRX_ADDR_IRQ_STAT  32'h4000_8020
`define SRX_ADDR_IRQ_MASK  32'h4000_8024
`define SRX_ADDR_RX_CNT    32'h4000_8104
`define SRX_ADDR_TX_CNT    32'h4000_810C
`define SRX_ADDR_RX_NXT    32'h4000_8114
`define SRX_ADDR_TX_NXT    32'h4000_811C

// Control command bits
`define SRX_CTRL_ENABLE    0
`define SRX_CTRL_DISABLE   1

// Mode configuration fields
`define SRX_MODE_MASTER    0
`define SRX_MODE_VARSEL    1
`define SRX_MODE_FLTDIS    4
`define SRX_MODE_WAITRD    5
`define SRX_MODE_BITS_LSB  8
`define SRX_MODE_BITS_W    4
`define SRX_MODE_RESET     32'h0000_0000

// Status bit positions
`define SRX_ST_RXFULL      0
`define SRX_ST_TXEMPTY     1
`define SRX_ST_MODEFLT     2
`define SRX_ST_OVERRUN     3
`define SRX_ST_RXDONE      4
`define SRX_ST_TXDONE      5
`define SRX_ST_RXBOTH      6
`define SRX_ST_ENABLED     16
`define SRX_EV_W           7

// Received word layout
`define SRX_RD_TAG_LSB     16

// Word length coding
`define SRX_LEN_BASE       5'h08
`define SRX_LEN_MAX        5'h10
`define SRX_BITS_MAXCODE   4'h8

`endif

// File: src/srx_status.v
// Chosen here: the address-and-strobe port.
`timescale 1ns/1ps
`include "srx_regs.vh"
module srx_status #(
    parameter DATA_W = 16,
    parameter CS_W   = 4,
    parameter CNT_W  = 16
) (
    input  wire              mclk_i,
    input  wire              reset_n_i,
    input  wire [31:0]       addr_i,
    input  wire [31:0]       wdata_i,
    input  wire              wr_i,
    input  wire              rd_i,
    output reg  [31:0]       rdata_o,
    input  wire              sclk_i,
    input  wire              mosi_i,
    input  wire              slave_select_in_i,
    input  wire [CS_W-1:0]   chip_select_pins_i,
    input  wire              master_word_valid_i,
    input  wire [DATA_W-1:0] master_word_i,
    input  wire              tx_load_i,
    input  wire              rx_xfer_i,
    input  wire              tx_xfer_i,
    output wire [DATA_W-1:0] tx_word_o,
    output wire              enabled_o,
    output wire              master_mode_o,
    output wire              hold_transfer_o,
    output wire              irq_o
);

    // Pin synchronisers; first stage feeds only the second
    reg  [2:0]        sclk_sync_q;
    reg  [1:0]        mosi_sync_q;
    reg  [1:0]        ss_sync_q;
    wire              sclk_rise;
    wire              mosi_s;
    wire              ss_s;

    reg  [31:0]       mode_q;
    reg               enabled_q;
    reg  [DATA_W-1:0] tx_data_q;
    reg  [DATA_W-1:0] rx_word_q;
    reg  [CS_W-1:0]   rx_tag_q;
    reg               rx_full_q;
    reg               tx_empty_q;
    reg               mode_fault_q;
    reg               overrun_q;
    reg  [DATA_W-1:0] shift_q;
    reg  [4:0]        bit_cnt_q;
    reg               slave_load_q;
    reg  [DATA_W-1:0] slave_word_q;
    reg  [`SRX_EV_W-1:0] irq_stat_q;
    reg  [`SRX_EV_W-1:0] irq_mask_q;
    reg  [`SRX_EV_W-1:0] flags_prev_q;

    wire [2*CNT_W-1:0] cnt_all;
    wire [2*CNT_W-1:0] nxt_all;
    wire [1:0]         done_all;

    reg  [31:0]       status_r;
    reg  [31:0]       rxword_r;
    reg  [31:0]       read_r;

    wire              is_master;
    wire [3:0]        bits_code;
    wire [4:0]        word_len;
    wire [DATA_W-1:0] len_mask;
    wire [DATA_W-1:0] shift_next;
    wire              wr_ctrl;
    wire              wr_mode;
    wire              wr_tx;
    wire              wr_istat;
    wire              wr_imask;
    wire [1:0]        wr_cnt;
    wire [1:0]        wr_nxt;
    wire [1:0]        xfer;
    wire              rd_rx;
    wire              rd_status;
    wire              en_cmd;
    wire              dis_cmd;
    wire              fault_det;
    wire              rx_load;
    wire [DATA_W-1:0] rx_load_data;
    wire              rx_both;
    wire [`SRX_EV_W-1:0] flags_now;
    wire [`SRX_EV_W-1:0] events;

    assign sclk_rise = sclk_sync_q[1] & ~sclk_sync_q[2];
    assign mosi_s    = mosi_sync_q[1];
    assign ss_s      = ss_sync_q[1];

    assign is_master  = mode_q[`SRX_MODE_MASTER];
    assign bits_code  = mode_q[`SRX_MODE_BITS_LSB +: `SRX_MODE_BITS_W];
    assign word_len   = (bits_code > `SRX_BITS_MAXCODE) ? `SRX_LEN_MAX :
                        (`SRX_LEN_BASE + {1'b0, bits_code});
    assign len_mask   = ~({DATA_W{1'b1}} << word_len);
    assign shift_next = {shift_q[DATA_W-2:0], mosi_s};

    // Only the documented writable addresses decode; others are dropped
    assign wr_ctrl   = wr_i && (addr_i == `SRX_ADDR_CTRL);
    assign wr_mode   = wr_i && (addr_i == `SRX_ADDR_MODE);
    assign wr_tx     = wr_i && (addr_i == `SRX_ADDR_TXDATA);
    assign wr_istat  = wr_i && (addr_i == `SRX_ADDR_IRQ_STAT);
    assign wr_imask  = wr_i && (addr_i == `SRX_ADDR_IRQ_MASK);
    assign wr_cnt[0] = wr_i && (addr_i == `SRX_ADDR_RX_CNT);
    assign wr_cnt[1] = wr_i && (addr_i == `SRX_ADDR_TX_CNT);
    assign wr_nxt[0] = wr_i && (addr_i == `SRX_ADDR_RX_NXT);
    assign wr_nxt[1] = wr_i && (addr_i == `SRX_ADDR_TX_NXT);
    assign xfer      = {tx_xfer_i, rx_xfer_i};
    assign rd_rx     = rd_i && (addr_i == `SRX_ADDR_RXWORD);
    assign rd_status = rd_i && (addr_i == `SRX_ADDR_STATUS);

    assign en_cmd  = wr_ctrl & wdata_i[`SRX_CTRL_ENABLE];
    assign dis_cmd = wr_ctrl & wdata_i[`SRX_CTRL_DISABLE];

    // Another master pulling select low while we are master
    assign fault_det = enabled_q & is_master & ~mode_q[`SRX_MODE_FLTDIS] & ~ss_s;

    assign rx_load      = slave_load_q | (master_word_valid_i & is_master & enabled_q);
    assign rx_load_data = slave_load_q ? slave_word_q : (master_word_i & len_mask);

    assign rx_both = (cnt_all[0 +: CNT_W] == {CNT_W{1'b0}}) &&
                     (nxt_all[0 +: CNT_W] == {CNT_W{1'b0}});

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sclk_sync_q <= 3'h0;
            mosi_sync_q <= 2'h0;
            ss_sync_q   <= 2'h3;
        end else begin
            sclk_sync_q <= {sclk_sync_q[1:0], sclk_i};
            mosi_sync_q <= {mosi_sync_q[0], mosi_i};
            ss_sync_q   <= {ss_sync_q[0], slave_select_in_i};
        end
    end

    // Slave receive shifter, samples on rising serial clock only
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shift_q      <= {DATA_W{1'b0}};
            bit_cnt_q    <= 5'h00;
            slave_load_q <= 1'b0;
            slave_word_q <= {DATA_W{1'b0}};
        end else begin
            slave_load_q <= 1'b0;
            if (!enabled_q || is_master || ss_s) begin
                bit_cnt_q <= 5'h00;
            end else if (sclk_rise) begin
                shift_q <= shift_next;
                if (bit_cnt_q == word_len - 5'h01) begin
                    bit_cnt_q    <= 5'h00;
                    slave_load_q <= 1'b1;
                    slave_word_q <= shift_next & len_mask;
                end else begin
                    bit_cnt_q <= bit_cnt_q + 5'h01;
                end
            end
        end
    end

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            mode_q    <= `SRX_MODE_RESET;
            enabled_q <= 1'b0;
            tx_data_q <= {DATA_W{1'b0}};
        end else begin
            if (wr_mode) begin
                mode_q <= wdata_i;
            end
            if (fault_det || dis_cmd) begin
                enabled_q <= 1'b0;
            end else if (en_cmd) begin
                enabled_q <= 1'b1;
            end
            if (wr_tx) begin
                tx_data_q <= wdata_i[DATA_W-1:0];
            end
        end
    end

    // Received word and its tag; new data always overwrites
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_word_q <= {DATA_W{1'b0}};
            rx_tag_q  <= {CS_W{1'b0}};
        end else if (rx_load) begin
            rx_word_q <= rx_load_data;
            rx_tag_q  <= is_master ? chip_select_pins_i : {CS_W{1'b0}};
        end
    end

    // Flags; a hardware set beats a same-cycle clear, except tx empty, where a TXDATA write beats a same-cycle tx load
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rx_full_q    <= 1'b0;
            tx_empty_q   <= 1'b0;
            mode_fault_q <= 1'b0;
            overrun_q    <= 1'b0;
        end else begin
            if (rx_load) begin
                rx_full_q <= 1'b1;
            end else if (rd_rx) begin
                rx_full_q <= 1'b0;
            end
            if (fault_det || dis_cmd) begin
                tx_empty_q <= 1'b0;
            end else if (en_cmd) begin
                tx_empty_q <= 1'b1;
            end else if (wr_tx) begin
                tx_empty_q <= 1'b0;
            end else if (tx_load_i && enabled_q) begin
                tx_empty_q <= 1'b1;
            end
            if (fault_det) begin
                mode_fault_q <= 1'b1;
            end else if (rd_status) begin
                mode_fault_q <= 1'b0;
            end
            // Second load while the previous word is still unread
            if (rx_load && rx_full_q && !rd_rx) begin
                overrun_q <= 1'b1;
            end else if (rd_status) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // Buffer-transfer counters, rx at index 0 and tx at index 1
    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : g_chan
            reg  [CNT_W-1:0] cnt_q;
            reg  [CNT_W-1:0] nxt_q;
            reg              done_q;
            wire             reach_zero;
            assign reach_zero = xfer[g] && !wr_cnt[g] &&
                                (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});
            assign cnt_all[g*CNT_W +: CNT_W] = cnt_q;
            assign nxt_all[g*CNT_W +: CNT_W] = nxt_q;
            assign done_all[g]               = done_q;
            always @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    cnt_q  <= {CNT_W{1'b0}};
                    nxt_q  <= {CNT_W{1'b0}};
                    done_q <= 1'b0;
                end else begin
                    if (wr_cnt[g]) begin
                        cnt_q <= wdata_i[CNT_W-1:0];
                    end else if (xfer[g] && cnt_q != {CNT_W{1'b0}}) begin
                        if (reach_zero && nxt_q != {CNT_W{1'b0}}) begin
                            cnt_q <= nxt_q;
                            nxt_q <= {CNT_W{1'b0}};
                        end else begin
                            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
                        end
                    end
                    if (wr_nxt[g]) begin
                        nxt_q <= wdata_i[CNT_W-1:0];
                    end
                    if (reach_zero) begin
                        done_q <= 1'b1;
                    end else if (wr_cnt[g] || wr_nxt[g]) begin
                        done_q <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    always @* begin
        status_r = 32'h0000_0000;
        status_r[`SRX_ST_RXFULL]  = rx_full_q;
        status_r[`SRX_ST_TXEMPTY] = tx_empty_q;
        status_r[`SRX_ST_MODEFLT] = mode_fault_q;
        status_r[`SRX_ST_OVERRUN] = overrun_q;
        status_r[`SRX_ST_RXDONE]  = done_all[0];
        status_r[`SRX_ST_TXDONE]  = done_all[1];
        status_r[`SRX_ST_RXBOTH]  = rx_both;
        status_r[`SRX_ST_ENABLED] = enabled_q;
    end

    always @* begin
        rxword_r = 32'h0000_0000;
        rxword_r[DATA_W-1:0] = rx_word_q;
        rxword_r[`SRX_RD_TAG_LSB +: CS_W] = is_master ? rx_tag_q : {CS_W{1'b0}};
    end

    // Interrupt status latches rising edges of the status flags
    assign flags_now = status_r[`SRX_EV_W-1:0];
    assign events    = flags_now & ~flags_prev_q;

    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flags_prev_q <= {`SRX_EV_W{1'b0}};
            irq_stat_q   <= {`SRX_EV_W{1'b0}};
            irq_mask_q   <= {`SRX_EV_W{1'b0}};
        end else begin
            flags_prev_q <= flags_now;
            if (wr_istat) begin
                irq_stat_q <= (irq_stat_q & ~wdata_i[`SRX_EV_W-1:0]) | events;
            end else begin
                irq_stat_q <= irq_stat_q | events;
            end
            if (wr_imask) begin
                irq_mask_q <= wdata_i[`SRX_EV_W-1:0];
            end
        end
    end

    always @* begin
        case (addr_i)
            `SRX_ADDR_MODE:     read_r = mode_q;
            `SRX_ADDR_RXWORD:   read_r = rxword_r;
            `SRX_ADDR_STATUS:   read_r = status_r;
            `SRX_ADDR_IRQ_STAT: read_r = {{(32-`SRX_EV_W){1'b0}}, irq_stat_q};
            `SRX_ADDR_IRQ_MASK: read_r = {{(32-`SRX_EV_W){1'b0}}, irq_mask_q};
            `SRX_ADDR_RX_CNT:   read_r = {{(32-CNT_W){1'b0}}, cnt_all[0 +: CNT_W]};
            `SRX_ADDR_TX_CNT:   read_r = {{(32-CNT_W){1'b0}}, cnt_all[CNT_W +: CNT_W]};
            `SRX_ADDR_RX_NXT:   read_r = {{(32-CNT_W){1'b0}}, nxt_all[0 +: CNT_W]};
            `SRX_ADDR_TX_NXT:   read_r = {{(32-CNT_W){1'b0}}, nxt_all[CNT_W +: CNT_W]};
            default:            read_r = 32'h0000_0000;
        endcase
    end

    // Read data valid only in the cycle after the strobe
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            rdata_o <= read_r;
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    assign tx_word_o     = tx_data_q;
    assign enabled_o     = enabled_q;
    assign master_mode_o = is_master;
    // Master shifter waits for the unread word so its tag is not lost
    assign hold_transfer_o = mode_q[`SRX_MODE_WAITRD] & rx_full_q;
    assign irq_o         = |(irq_stat_q & irq_mask_q);

endmodule

// File: dv/srx_ser_master.sv
`timescale 1ns/1ps
module srx_ser_master (
    output logic sclk_o,
    output logic mosi_o,
    output logic sel_n_o
);
    initial begin
        sclk_o = 1'b0;
        mosi_o = 1'b1;
        sel_n_o = 1'b1;
    end
    // Mode 0, MSB first; clock rests low outside frames
    task automatic send(input logic [15:0] w, input int n);
        // Off the mclk edge so synchroniser sampling is deterministic
        #1 sel_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            mosi_o = w[i];
            #40 sclk_o = 1'b1;
            #40 sclk_o = 1'b0;
        end
        #40 sel_n_o = 1'b1;
        // Released line must not keep the last bit
        mosi_o = ~mosi_o;
    endtask
    task automatic hold_select(input logic lvl);
        sel_n_o = lvl;
    endtask
endmodule

// File: dv/srx_status_chk.sv
`timescale 1ns/1ps
`include "srx_regs.vh"
module srx_status_chk #(
    parameter DATA_W = 16,
    parameter CS_W   = 4
) (
    input wire logic              mclk_i,
    input wire logic              reset_n_i,
    input wire logic [31:0]       addr_i,
    input wire logic [31:0]       wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [31:0]       rdata_o,
    input wire logic              slave_select_in_i,
    input wire logic [CS_W-1:0]   chip_select_pins_i,
    input wire logic              master_word_valid_i,
    input wire logic [DATA_W-1:0] master_word_i,
    input wire logic              enabled_o,
    input wire logic              master_mode_o,
    input wire logic              irq_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    wire rd_st = rd_i && (addr_i == `SRX_ADDR_STATUS);
    wire rd_wd = rd_i && (addr_i == `SRX_ADDR_RXWORD);
    // Shadow of the fault-disable bit; a disabled detector must not fire
    logic flt_dis_q;
    always @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            flt_dis_q <= 1'b0;
        end else if (wr_i && addr_i == `SRX_ADDR_MODE) begin
            flt_dis_q <= wdata_i[`SRX_MODE_FLTDIS];
        end
    end
    chk_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read answer");
    chk_status_rsvd: assert property ($past(rd_st) |->
        (rdata_o & 32'hFFFE_FF80) == 32'h0000_0000) else $error("reserved status bit set");
    chk_word_upper: assert property ($past(rd_wd) |->
        (rdata_o >> (`SRX_RD_TAG_LSB + CS_W)) == 32'h0000_0000) else $error("word upper bits set");
    chk_tag_slave: assert property ($past(rd_wd && !master_mode_o) |->
        rdata_o[`SRX_RD_TAG_LSB +: CS_W] == {CS_W{1'b0}}) else $error("tag not zero in slave mode");
    chk_txe_off: assert property ($past(rd_st && !enabled_o) |->
        !rdata_o[`SRX_ST_TXEMPTY]) else $error("tx empty set while disabled");
    chk_fault_off: assert property (
        (!slave_select_in_i && master_mode_o && !flt_dis_q)[*3] ##0 enabled_o
        |=> !enabled_o) else $error("select low did not disable master");
    chk_irq_mask0: assert property (
        $past(wr_i && addr_i == `SRX_ADDR_IRQ_MASK && wdata_i == 32'h0000_0000) |-> !irq_o)
        else $error("interrupt high with all masked");
    chk_master_tag: assert property (master_word_valid_i && master_mode_o && enabled_o ##1
        (rd_wd && !master_word_valid_i) |=> rdata_o[CS_W+DATA_W-1:0] ==
        {$past(chip_select_pins_i, 2), $past(master_word_i, 2)}) else $error("master word wrong");
    cover property (rd_wd ##1 rdata_o != 32'h0000_0000);
    cover property (enabled_o ##1 !enabled_o);
    cover property (irq_o);
    cover property (master_word_valid_i && master_mode_o);
endmodule
bind srx_status srx_status_chk #(.DATA_W(DATA_W), .CS_W(CS_W)) i_chk (.*);

// File: dv/test_srx_status.sv
`timescale 1ns/1ps
`include "srx_regs.vh"
module test_srx_status;
    logic        mclk_i;
    logic        reset_n_i;
    logic [31:0] addr_i;
    logic [31:0] wdata_i;
    logic        wr_i;
    logic        rd_i;
    logic [3:0]  chip_select_pins_i;
    logic        master_word_valid_i;
    logic [15:0] master_word_i;
    logic        tx_load_i;
    logic        rx_xfer_i;
    logic        tx_xfer_i;
    wire  [31:0] rdata_o;
    wire  [15:0] tx_word_o;
    wire         enabled_o;
    wire         master_mode_o;
    wire         hold_transfer_o;
    wire         irq_o;
    wire         sclk_i;
    wire         mosi_i;
    wire         slave_select_in_i;
    int          bad_count;
    int          comparisons;
    int          seed;
    int          rxf, txe, mf, ov, rxd, txd, en, rc, rn, tc, tn;
    logic [31:0] word;
    logic [31:0] got;
    logic [31:0] v;
    srx_status i_dut (.*);
    srx_ser_master i_ser (.sclk_o(sclk_i), .mosi_o(mosi_i), .sel_n_o(slave_select_in_i));
    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic end_of_test();
        $display("Comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", n, e, g);
            bad_count++;
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic rd(input logic [31:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(posedge mclk_i);
        got = rdata_o;
    endtask
    task automatic st();
        rd(`SRX_ADDR_STATUS);
        chk("status", {15'h0000, en[0], 9'h000, 1'(rc == 0 && rn == 0), txd[0], rxd[0],
            ov[0], mf[0], txe[0], rxf[0]}, got);
        chk("enabled", {31'h0000_0000, en[0]}, {31'h0000_0000, enabled_o});
        mf = 0;
        ov = 0;
    endtask
    task automatic rw();
        rd(`SRX_ADDR_RXWORD);
        chk("rx word", word, got);
        rxf = 0;
    endtask
    task automatic load(input logic [31:0] w);
        ov = ov | rxf;
        rxf = 1;
        word = w;
    endtask
    // Caller lets an edge pass before pulsing the same line again
    task automatic pulse(input logic [3:0] p);
        {master_word_valid_i, tx_load_i, rx_xfer_i, tx_xfer_i} <= p;
        @(posedge mclk_i);
        {master_word_valid_i, tx_load_i, rx_xfer_i, tx_xfer_i} <= 4'h0;
    endtask
    task automatic dec(inout int c, inout int n, inout int d);
        if (c != 0) begin
            c--;
            if (c == 0) begin
                d = 1;
                c = n;
                n = 0;
            end
        end
    endtask
    initial begin
        #200000;
        bad_count++;
        end_of_test();
    end
    initial begin
        seed = 32'hf459_b8f6;
        {reset_n_i, wr_i, rd_i, master_word_valid_i, tx_load_i, rx_xfer_i, tx_xfer_i} = 7'h00;
        addr_i = 32'h0000_0000;
        wdata_i = 32'h0000_0000;
        chip_select_pins_i = 4'h0;
        master_word_i = 16'h0000;
        word = 32'h0000_0000;
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        @(posedge mclk_i);
        st();
        wr(`SRX_ADDR_STATUS, 32'hFFFF_FFFF);
        wr(`SRX_ADDR_RXWORD, 32'hFFFF_FFFF);
        pulse(4'h4);
        st();
        rw();
        rd(32'h4000_8030);
        chk("unmapped", 32'h0000_0000, got);
        wr(`SRX_ADDR_CTRL, 32'h0000_0001);
        en = 1;
        txe = 1;
        st();
        v = $random(seed);
        wr(`SRX_ADDR_TXDATA, v);
        txe = 0;
        chk("tx word", {16'h0000, v[15:0]}, {16'h0000, tx_word_o});
        st();
        pulse(4'h4);
        txe = 1;
        st();
        for (int k = 0; k <= 8; k += 4) begin
            wr(`SRX_ADDR_MODE, 32'h0000_0022 | (k << 8));
            v = $random(seed) & ((1 << (8 + k)) - 1);
            i_ser.send(v[15:0], 8 + k);
            @(posedge mclk_i);
            chk("hold", 32'h0000_0001, {31'h0000_0000, hold_transfer_o});
            load(v);
            st();
            rw();
            chk("hold", 32'h0000_0000, {31'h0000_0000, hold_transfer_o});
        end
        wr(`SRX_ADDR_MODE, 32'h0000_0000);
        for (int k = 0; k < 2; k++) begin
            v = $random(seed) & 32'h0000_00FF;
            i_ser.send(v[15:0], 8);
            @(posedge mclk_i);
            load(v);
        end
        st();
        rw();
        st();
        wr(`SRX_ADDR_MODE, 32'h0000_0001);
        chk("master", 32'h0000_0001, {31'h0000_0000, master_mode_o});
        wr(`SRX_ADDR_IRQ_STAT, 32'h0000_007F);
        wr(`SRX_ADDR_IRQ_MASK, 32'h0000_0001);
        v = $random(seed);
        chip_select_pins_i <= v[19:16];
        master_word_i <= {8'h00, v[7:0]};
        pulse(4'h8);
        load({12'h000, v[19:16], 8'h00, v[7:0]});
        rw();
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq_o});
        wr(`SRX_ADDR_IRQ_MASK, 32'h0000_0000);
        chk("irq", 32'h0000_0000, {31'h0000_0000, irq_o});
        wr(`SRX_ADDR_IRQ_MASK, 32'h0000_0001);
        chk("irq", 32'h0000_0001, {31'h0000_0000, irq_o});
        wr(`SRX_ADDR_IRQ_STAT, 32'h0000_0001);
        chk("irq", 32'h0000_0000, {31'h0000_0000, irq_o});
        // Off the edge so the synchroniser timing is deterministic
        #1 i_ser.hold_select(1'b0);
        repeat (6) @(posedge mclk_i);
        mf = 1;
        en = 0;
        txe = 0;
        st();
        st();
        i_ser.hold_select(1'b1);
        repeat (4) @(posedge mclk_i);
        wr(`SRX_ADDR_CTRL, 32'h0000_0001);
        en = 1;
        txe = 1;
        st();
        // Fault detection off: select low must be ignored
        wr(`SRX_ADDR_MODE, 32'h0000_0011);
        i_ser.hold_select(1'b0);
        repeat (6) @(posedge mclk_i);
        st();
        i_ser.hold_select(1'b1);
        repeat (4) @(posedge mclk_i);
        wr(`SRX_ADDR_MODE, 32'h0000_0001);
        wr(`SRX_ADDR_RX_CNT, 32'h0000_0002);
        rc = 2;
        wr(`SRX_ADDR_RX_NXT, 32'h0000_0001);
        rn = 1;
        st();
        for (int k = 0; k < 3; k++) begin
            pulse(4'h2);
            @(posedge mclk_i);
            dec(rc, rn, rxd);
            st();
        end
        wr(`SRX_ADDR_RX_NXT, 32'h0000_0000);
        rxd = 0;
        st();
        wr(`SRX_ADDR_RX_CNT, 32'h0000_0001);
        rc = 1;
        st();
        wr(`SRX_ADDR_TX_CNT, 32'h0000_0001);
        tc = 1;
        pulse(4'h1);
        @(posedge mclk_i);
        dec(tc, tn, txd);
        st();
        wr(`SRX_ADDR_TX_NXT, 32'h0000_0000);
        txd = 0;
        st();
        end_of_test();
    end
endmodule
